// *** rcr_top.sv ***
// Regulator control register bank with Avalon-MM slave and four channels
// Assumes synchronous GPIO levels and a one-cycle standby entry pulse
//
// Our own choice: the Avalon-MM interface to the registers.
module rcr_top import rcr_pkg::*; #(
    parameter logic [RCR_RESET_W-1:0] VOLT_RESET = RCR_VOLT_RESET_DEF,
    parameter logic [RCR_RESET_W-1:0] ENA_RESET = RCR_ENA_RESET_DEF
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic standby_entry,
    input wire logic [2:0] gpio_level,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [4:0] reg3_voltage_code,
    output logic reg3_switch_mode,
    output logic reg3_on,
    output logic [3:0] reg3_phase_select,
    output logic [4:0] reg4_voltage_code,
    output logic reg4_switch_mode,
    output logic reg4_on,
    output logic [3:0] reg4_phase_select,
    output logic [4:0] reg5_voltage_code,
    output logic reg5_switch_mode,
    output logic reg5_on,
    output logic [3:0] reg5_phase_select,
    output logic [4:0] reg6_voltage_code,
    output logic reg6_switch_mode,
    output logic reg6_on,
    output logic [3:0] reg6_phase_select
);
    rcr_bus_state_t bus_state;
    rcr_bus_state_t next_bus_state;
    rcr_dec_t dec;
    rcr_volt_t volt [RCR_NUM_REG];
    rcr_ena_t ena [RCR_NUM_REG];
    rcr_out_t status [RCR_NUM_REG];
    logic [3:0] on_bits;
    logic bus_req;
    logic wr_fire;
    logic wr_volt;
    logic wr_ena;
    logic [31:0] next_readdata;
    logic [RCR_RESET_W-1:0] volt_image;
    logic [RCR_RESET_W-1:0] ena_image;

    default clocking rcr_cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    // Bus request decode
    assign bus_req = avs_read | avs_write;
    assign dec = rcr_decode(avs_address[7:2]);
    assign wr_fire = avs_write & (bus_state == RCR_BUS_ANSWER) & avs_byteenable[0];
    assign wr_volt = wr_fire & dec.hit & !dec.is_ena & !dec.is_status;
    assign wr_ena = wr_fire & dec.hit & dec.is_ena;

    // One wait cycle per access
    assign avs_waitrequest = bus_req & (bus_state == RCR_BUS_IDLE);

    always_comb begin
        case (bus_state)
            RCR_BUS_IDLE: next_bus_state = bus_req ? RCR_BUS_ANSWER : RCR_BUS_IDLE;
            RCR_BUS_ANSWER: next_bus_state = RCR_BUS_IDLE;
            default: next_bus_state = RCR_BUS_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bus_state <= RCR_BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    // Read multiplexer, upper bits always zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (dec.hit && dec.is_status) begin
            next_readdata[3:0] = on_bits;
        end else if (dec.hit && dec.is_ena) begin
            next_readdata[5:0] = ena[dec.sel];
        end else if (dec.hit) begin
            next_readdata[5:0] = volt[dec.sel];
        end
    end

    // Read data loaded in the wait cycle, held through the answer
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && bus_state == RCR_BUS_IDLE) begin
            avs_readdata <= next_readdata;
        end
    end

    // Voltage-select registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < RCR_NUM_REG; i++) begin
                volt[i] <= rcr_volt_t'(VOLT_RESET[i*RCR_FIELD_W +: RCR_FIELD_W]);
            end
        end else if (standby_entry) begin
            for (int i = 0; i < RCR_NUM_REG; i++) begin
                volt[i] <= rcr_volt_t'(VOLT_RESET[i*RCR_FIELD_W +: RCR_FIELD_W]);
            end
        end else if (wr_volt) begin
            volt[dec.sel] <= rcr_volt_t'(avs_writedata[5:0]);
        end
    end

    // Enable registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < RCR_NUM_REG; i++) begin
                ena[i] <= rcr_ena_t'(ENA_RESET[i*RCR_FIELD_W +: RCR_FIELD_W]);
            end
        end else if (standby_entry) begin
            for (int i = 0; i < RCR_NUM_REG; i++) begin
                ena[i] <= rcr_ena_t'(ENA_RESET[i*RCR_FIELD_W +: RCR_FIELD_W]);
            end
        end else if (wr_ena) begin
            ena[dec.sel] <= rcr_ena_t'(avs_writedata[5:0]);
        end
    end

    // Per-regulator output stages
    genvar g;
    generate
        for (g = 0; g < RCR_NUM_REG; g++) begin : gen_chan
            rcr_channel u_chan (
                .mclk(mclk),
                .reset_n(reset_n),
                .volt(volt[g]),
                .ena(ena[g]),
                .gpio_level(gpio_level),
                .status(status[g])
            );
            assign on_bits[g] = status[g].regulator_on;
        end
    endgenerate

    assign reg3_voltage_code = status[0].voltage_code;
    assign reg3_switch_mode = status[0].switch_mode;
    assign reg3_on = status[0].regulator_on;
    assign reg3_phase_select = status[0].phase;
    assign reg4_voltage_code = status[1].voltage_code;
    assign reg4_switch_mode = status[1].switch_mode;
    assign reg4_on = status[1].regulator_on;
    assign reg4_phase_select = status[1].phase;
    assign reg5_voltage_code = status[2].voltage_code;
    assign reg5_switch_mode = status[2].switch_mode;
    assign reg5_on = status[2].regulator_on;
    assign reg5_phase_select = status[2].phase;
    assign reg6_voltage_code = status[3].voltage_code;
    assign reg6_switch_mode = status[3].switch_mode;
    assign reg6_on = status[3].regulator_on;
    assign reg6_phase_select = status[3].phase;

    // Packed views of both banks for the checks
    always_comb begin
        volt_image = '0;
        ena_image = '0;
        for (int i = 0; i < RCR_NUM_REG; i++) begin
            volt_image[i*RCR_FIELD_W +: RCR_FIELD_W] = volt[i];
            ena_image[i*RCR_FIELD_W +: RCR_FIELD_W] = ena[i];
        end
    end

    // Checks on the register bank
    a_standby_volt: assert property (@(posedge mclk) disable iff (!reset_n)
        standby_entry |=> (volt[0] == rcr_volt_t'(VOLT_RESET[5:0]))
                          && (volt[3] == rcr_volt_t'(VOLT_RESET[23:18])))
        else $error("voltage registers not reloaded on standby");
    a_standby_ena: assert property (@(posedge mclk) disable iff (!reset_n)
        standby_entry |=> (ena[1] == rcr_ena_t'(ENA_RESET[11:6]))
                          && (ena[2] == rcr_ena_t'(ENA_RESET[17:12])))
        else $error("enable registers not reloaded on standby");
    a_standby_output: assert property (@(posedge mclk) disable iff (!reset_n)
        standby_entry |=> ##1 reg3_phase_select
                              == rcr_phase_onehot(ENA_RESET[5:4]))
        else $error("phase output not back at reset value after standby");
    a_variant_reset: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(reset_n) |-> (volt[1] == rcr_volt_t'(VOLT_RESET[11:6]))
                           && (ena[3] == rcr_ena_t'(ENA_RESET[23:18])))
        else $error("reset value not the variant parameter");
    a_reserved_read: assert property (@(posedge mclk) disable iff (!reset_n)
        (avs_read && bus_state == RCR_BUS_ANSWER) |-> avs_readdata[31:6] == 26'h0)
        else $error("reserved bits read as nonzero");
    a_write_lands: assert property (@(posedge mclk) disable iff (!reset_n)
        (wr_volt && !standby_entry) |=> volt[$past(dec.sel)] == $past(avs_writedata[5:0]))
        else $error("voltage write lost or not masked");
    a_write_output: assert property (@(posedge mclk) disable iff (!reset_n)
        (wr_volt && !standby_entry && dec.sel == 2'h0 && avs_writedata[4:0] == 5'h1F)
        |=> ##1 reg3_voltage_code == 5'h1B)
        else $error("written all-ones code did not saturate at output");
    a_ena_drives_on: assert property (@(posedge mclk) disable iff (!reset_n)
        (wr_ena && !standby_entry && dec.sel == 2'h1 && avs_writedata[0])
        |=> ##1 reg4_on [*2])
        else $error("force bit write did not hold regulator on");
    a_wait_bound: assert property (@(posedge mclk) disable iff (!reset_n)
        bus_req |-> ##[0:1] !avs_waitrequest)
        else $error("bus access not answered within one wait cycle");
    a_status_read: assert property (@(posedge mclk) disable iff (!reset_n)
        (avs_read && bus_state == RCR_BUS_IDLE && dec.is_status)
        |=> avs_readdata[3:0] == $past(on_bits))
        else $error("status read does not show on bits");

    // Bus handshake
    a_wait_first: assert property ((bus_req && bus_state == RCR_BUS_IDLE)
        |-> avs_waitrequest)
        else $error("request not stalled in first cycle");

    a_wait_answer: assert property ((bus_req && bus_state == RCR_BUS_ANSWER)
        |-> !avs_waitrequest)
        else $error("request stalled in answer cycle");

    a_answer_once: assert property ((bus_state == RCR_BUS_ANSWER)
        |=> bus_state == RCR_BUS_IDLE)
        else $error("answer state lasted more than one cycle");

    // Read path
    a_read_volt: assert property ((avs_read && bus_state == RCR_BUS_IDLE && dec.hit
        && !dec.is_ena && !dec.is_status) |=> avs_readdata[5:0] == $past(volt[dec.sel]))
        else $error("voltage register read back wrong");

    a_read_ena: assert property ((avs_read && bus_state == RCR_BUS_IDLE && dec.is_ena)
        |=> avs_readdata[5:0] == $past(ena[dec.sel]))
        else $error("enable register read back wrong");

    a_read_unmapped: assert property ((avs_read && bus_state == RCR_BUS_IDLE && !dec.hit)
        |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_status_upper: assert property ((avs_read && bus_state == RCR_BUS_IDLE && dec.is_status)
        |=> avs_readdata[31:4] == 28'h0)
        else $error("status read upper bits nonzero");

    a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");

    a_answer_hold: assert property ((avs_read && bus_state == RCR_BUS_ANSWER)
        |=> $stable(avs_readdata))
        else $error("read data changed in answer cycle");

    // Write path
    a_ena_lands: assert property ((wr_ena && !standby_entry)
        |=> ena[$past(dec.sel)] == $past(avs_writedata[5:0]))
        else $error("enable write lost or not masked");

    a_bank_hold: assert property ((!wr_fire && !standby_entry)
        |=> $stable(volt_image) && $stable(ena_image))
        else $error("register changed without write or standby");

    a_unmapped_write: assert property ((wr_fire && !dec.hit && !standby_entry)
        |=> $stable(volt_image) && $stable(ena_image))
        else $error("unmapped write changed a register");

    a_status_write: assert property ((wr_fire && dec.is_status && !standby_entry)
        |=> $stable(volt_image) && $stable(ena_image))
        else $error("status write changed a register");

    a_byte_gate: assert property ((avs_write && bus_state == RCR_BUS_ANSWER
        && !avs_byteenable[0] && !standby_entry) |=> $stable(volt_image) && $stable(ena_image))
        else $error("write without byte 0 changed a register");

    a_volt_one_write: assert property ((wr_volt && !standby_entry)
        |=> ena_image == $past(ena_image))
        else $error("voltage write touched an enable register");

    a_ena_one_write: assert property ((wr_ena && !standby_entry)
        |=> volt_image == $past(volt_image))
        else $error("enable write touched a voltage register");

    // Reset and standby images
    a_standby_all: assert property (standby_entry
        |=> volt_image == VOLT_RESET && ena_image == ENA_RESET)
        else $error("bank not reloaded on standby");

    a_reset_image: assert property ($rose(reset_n)
        |-> volt_image == VOLT_RESET && ena_image == ENA_RESET)
        else $error("bank not at variant values after reset");

    // Outputs
    a_code_range: assert property (reg3_voltage_code <= RCR_CODE_MAX
        && reg4_voltage_code <= RCR_CODE_MAX && reg5_voltage_code <= RCR_CODE_MAX
        && reg6_voltage_code <= RCR_CODE_MAX)
        else $error("output code above 3.6 V");

    a_phase_onehot: assert property ((reset_n && $past(reset_n))
        |-> $onehot(reg3_phase_select) && $onehot(reg4_phase_select)
            && $onehot(reg5_phase_select) && $onehot(reg6_phase_select))
        else $error("phase output not one-hot");

    a_phase_output: assert property ((wr_ena && !standby_entry && dec.sel == 2'h2)
        |=> ##1 reg5_phase_select == rcr_phase_onehot($past(avs_writedata[5:4], 2)))
        else $error("written phase not shown on output");

    a_switch_output: assert property ((wr_volt && !standby_entry && dec.sel == 2'h3)
        |=> ##1 reg6_switch_mode == $past(avs_writedata[5], 2))
        else $error("written switch bit not shown on output");

    a_gpio_on: assert property ((reset_n && ena[2].gpio2_gate && gpio_level[1])
        |=> reg5_on)
        else $error("GPIO2 term did not turn regulator on");

    c_write_read: cover property (@(posedge mclk) disable iff (!reset_n)
        wr_volt ##[1:8] (avs_read && bus_state == RCR_BUS_ANSWER));
    c_standby: cover property (@(posedge mclk) disable iff (!reset_n)
        reg3_on ##1 standby_entry);
    c_unmapped: cover property (@(posedge mclk) disable iff (!reset_n)
        avs_read && bus_state == RCR_BUS_ANSWER && !dec.hit);
    c_switch: cover property (@(posedge mclk) disable iff (!reset_n)
        reg6_switch_mode && reg6_on);
endmodule

// *** rcr_pkg.sv ***
// Constants, types and helpers of the regulator control register bank
// Assumes one clock, synchronous inputs and a byte-addressed Avalon-MM slave
// Behaviour
// - Code means 0.9 V plus 0.1 V steps, saturating
// - Bit 5 picks linear or switch mode
// - Bit 0, or bit 1 with GPIO1, enables
// - Bit 2 with GPIO2 high also enables
// - Bit 3 with GPIO3; all terms ORed
// - Enable bits 5:4 pick phase one to four
// - Standby entry reloads every register's reset value
// - Reset values are per-variant parameters
package rcr_pkg;
    localparam int RCR_NUM_REG = 4;
    localparam int RCR_FIELD_W = 6;
    localparam int RCR_RESET_W = RCR_NUM_REG * RCR_FIELD_W;
    // Highest code whose voltage stays within 3.6 V
    localparam logic [4:0] RCR_CODE_MAX = 5'h1B;

    // Register indices; byte address is four times the index
    localparam logic [5:0] RCR_IDX_REG3_VOLT = 6'h31;
    localparam logic [5:0] RCR_IDX_REG3_ENA = 6'h32;
    localparam logic [5:0] RCR_IDX_REG4_VOLT = 6'h33;
    localparam logic [5:0] RCR_IDX_REG4_ENA = 6'h34;
    localparam logic [5:0] RCR_IDX_REG5_VOLT = 6'h35;
    localparam logic [5:0] RCR_IDX_REG5_ENA = 6'h36;
    localparam logic [5:0] RCR_IDX_REG6_VOLT = 6'h37;
    localparam logic [5:0] RCR_IDX_REG6_ENA = 6'h38;
    localparam logic [5:0] RCR_IDX_STATUS = 6'h3F;

    // Default reset images, six bits per regulator, reg3 lowest
    localparam logic [RCR_RESET_W-1:0] RCR_VOLT_RESET_DEF = 24'h000000;
    localparam logic [RCR_RESET_W-1:0] RCR_ENA_RESET_DEF = 24'h000000;

    typedef struct packed {
        logic switch_mode;
        logic [4:0] code;
    } rcr_volt_t;

    typedef struct packed {
        logic [1:0] phase;
        logic gpio3_gate;
        logic gpio2_gate;
        logic gpio1_gate;
        logic force_on;
    } rcr_ena_t;

    typedef struct packed {
        logic regulator_on;
        logic switch_mode;
        logic [4:0] voltage_code;
        logic [3:0] phase;
    } rcr_out_t;

    typedef struct packed {
        logic hit;
        logic is_ena;
        logic is_status;
        logic [1:0] sel;
    } rcr_dec_t;

    typedef enum logic [0:0] {
        RCR_BUS_IDLE = 1'b0,
        RCR_BUS_ANSWER = 1'b1
    } rcr_bus_state_t;

    function automatic logic [4:0] rcr_sat_code(input logic [4:0] code);
        return (code > RCR_CODE_MAX) ? RCR_CODE_MAX : code;
    endfunction

    function automatic logic [3:0] rcr_phase_onehot(input logic [1:0] phase);
        return 4'h1 << phase;
    endfunction

    function automatic rcr_dec_t rcr_decode(input logic [5:0] idx);
        rcr_dec_t d;
        d = '0;
        d.hit = 1'b1;
        case (idx)
            RCR_IDX_REG3_VOLT: d.sel = 2'h0;
            RCR_IDX_REG3_ENA: begin d.sel = 2'h0; d.is_ena = 1'b1; end
            RCR_IDX_REG4_VOLT: d.sel = 2'h1;
            RCR_IDX_REG4_ENA: begin d.sel = 2'h1; d.is_ena = 1'b1; end
            RCR_IDX_REG5_VOLT: d.sel = 2'h2;
            RCR_IDX_REG5_ENA: begin d.sel = 2'h2; d.is_ena = 1'b1; end
            RCR_IDX_REG6_VOLT: d.sel = 2'h3;
            RCR_IDX_REG6_ENA: begin d.sel = 2'h3; d.is_ena = 1'b1; end
            RCR_IDX_STATUS: d.is_status = 1'b1;
            default: d.hit = 1'b0;
        endcase
        return d;
    endfunction
endpackage

// *** rcr_channel.sv ***
// One regulator's output stage: on condition, saturated code, phase
// Assumes gpio_level is synchronous to mclk
module rcr_channel import rcr_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input rcr_volt_t volt,
    input rcr_ena_t ena,
    input wire logic [2:0] gpio_level,
    output rcr_out_t status
);
    logic next_on;
    logic regulator_on;
    logic switch_mode;
    logic [4:0] voltage_code;
    logic [3:0] phase;

    // One driver for the whole status word
    assign status = {regulator_on, switch_mode, voltage_code, phase};

    // Enabling terms
    always_comb begin
        next_on = ena.force_on
            | (ena.gpio1_gate & gpio_level[0])
            | (ena.gpio2_gate & gpio_level[1])
            | (ena.gpio3_gate & gpio_level[2]);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            regulator_on <= 1'b0;
        end else begin
            regulator_on <= next_on;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            voltage_code <= 5'h00;
            switch_mode <= 1'b0;
        end else begin
            voltage_code <= rcr_sat_code(volt.code);
            switch_mode <= volt.switch_mode;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= 4'h0;
        end else begin
            phase <= rcr_phase_onehot(ena.phase);
        end
    end

    a_force_on: assert property (@(posedge mclk) disable iff (!reset_n)
        (reset_n && ena.force_on) |=> status.regulator_on)
        else $error("force bit did not turn regulator on");
    a_gpio1_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        (reset_n && ena.gpio1_gate && gpio_level[0]) |=> status.regulator_on)
        else $error("GPIO1 term did not turn regulator on");
    a_gpio2_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        (reset_n && ena.gpio2_gate && gpio_level[1]) |=> status.regulator_on)
        else $error("GPIO2 term did not turn regulator on");
    a_gpio3_or: assert property (@(posedge mclk) disable iff (!reset_n)
        (reset_n && ena.gpio3_gate && gpio_level[2]) |=> status.regulator_on)
        else $error("GPIO3 term did not turn regulator on");
    a_all_off: assert property (@(posedge mclk) disable iff (!reset_n)
        (reset_n && !ena.force_on && !(ena.gpio1_gate && gpio_level[0])
         && !(ena.gpio2_gate && gpio_level[1])
         && !(ena.gpio3_gate && gpio_level[2])) |=> !status.regulator_on)
        else $error("regulator on with no enabling term");
    a_code_sat: assert property (@(posedge mclk) disable iff (!reset_n)
        (reset_n && volt.code > RCR_CODE_MAX) |=> status.voltage_code == 5'h1B)
        else $error("code above 3.6 V not saturated");
    a_code_pass: assert property (@(posedge mclk) disable iff (!reset_n)
        (reset_n && volt.code <= RCR_CODE_MAX) |=> status.voltage_code == $past(volt.code))
        else $error("code in range altered");
    a_switch_sel: assert property (@(posedge mclk) disable iff (!reset_n)
        reset_n |=> status.switch_mode == $past(volt.switch_mode))
        else $error("switch mode not following bit 5");
    a_phase_map: assert property (@(posedge mclk) disable iff (!reset_n)
        (reset_n && ena.phase == 2'h3) |=> status.phase == 4'h8)
        else $error("code 11 not mapped to phase four");
    c_gpio_on: cover property (@(posedge mclk) disable iff (!reset_n)
        !status.regulator_on ##1 status.regulator_on && !ena.force_on);
endmodule

// *** tb_top.sv ***
// Self-checking bench for the regulator control register bank
// Assumes rcr_pkg and rcr_top are compiled first; one 20 MHz clock
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rcr_pkg::*;
    localparam logic [23:0] VOLT_INIT = {6'h00, 6'h18, 6'h1F, 6'h21};
    localparam logic [23:0] ENA_INIT = {6'h34, 6'h22, 6'h10, 6'h01};
    localparam int TIMEOUT_CYCLES = 20000;
    logic mclk, reset_n, standby_entry, avs_read, avs_write, avs_waitrequest;
    logic [2:0] gpio_level;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [4:0] code_o [4];
    logic sw_o [4];
    logic on_o [4];
    logic [3:0] ph_o [4];
    logic [5:0] vm [4];
    logic [5:0] em [4];
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;

    rcr_top #(.VOLT_RESET(VOLT_INIT), .ENA_RESET(ENA_INIT)) rcr_top_inst (
        .mclk(mclk), .reset_n(reset_n), .standby_entry(standby_entry), .gpio_level(gpio_level),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .reg3_voltage_code(code_o[0]), .reg3_switch_mode(sw_o[0]), .reg3_on(on_o[0]),
        .reg3_phase_select(ph_o[0]),
        .reg4_voltage_code(code_o[1]), .reg4_switch_mode(sw_o[1]), .reg4_on(on_o[1]),
        .reg4_phase_select(ph_o[1]),
        .reg5_voltage_code(code_o[2]), .reg5_switch_mode(sw_o[2]), .reg5_on(on_o[2]),
        .reg5_phase_select(ph_o[2]),
        .reg6_voltage_code(code_o[3]), .reg6_switch_mode(sw_o[3]), .reg6_on(on_o[3]),
        .reg6_phase_select(ph_o[3])
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == TIMEOUT_CYCLES) begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [5:0] vidx(input int n);
        return RCR_IDX_REG3_VOLT + 6'(2 * n);
    endfunction

    // Waits for waitrequest low, ends on the edge that takes the answer
    task automatic bus_xfer(input logic [5:0] idx, input logic wr, input logic [31:0] d, input logic [3:0] be,
                            output logic [31:0] rd);
        @(posedge mclk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr_reg(input logic [5:0] idx, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] dummy;
        bus_xfer(idx, 1'b1, d, be, dummy);
    endtask

    task automatic rd_chk(input string what, input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus_xfer(idx, 1'b0, 32'h0, 4'hF, d);
        chk(what, exp, d);
    endtask

    task automatic check_regs();
        for (int n = 0; n < 4; n++) begin
            rd_chk("voltage register", vidx(n), {26'h0, vm[n]});
            rd_chk("enable register", vidx(n) + 6'h01, {26'h0, em[n]});
        end
    endtask

    // Expected outputs worked out from the shadow registers and gpio
    task automatic check_outs();
        logic on;
        logic [4:0] code;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        for (int n = 0; n < 4; n++) begin
            on = em[n][0] | (em[n][1] & gpio_level[0]) | (em[n][2] & gpio_level[1]) | (em[n][3] & gpio_level[2]);
            code = (vm[n][4:0] > 5'h1B) ? 5'h1B : vm[n][4:0];
            chk("voltage code", {27'h0, code}, {27'h0, code_o[n]});
            chk("switch mode", {31'h0, vm[n][5]}, {31'h0, sw_o[n]});
            chk("regulator on", {31'h0, on}, {31'h0, on_o[n]});
            chk("phase select", {28'h0, 4'h1 << em[n][5:4]}, {28'h0, ph_o[n]});
        end
    endtask

    task automatic load_init();
        for (int n = 0; n < 4; n++) begin
            vm[n] = VOLT_INIT[6*n +: 6];
            em[n] = ENA_INIT[6*n +: 6];
        end
    endtask

    task automatic t_reset_values();
        load_init();
        check_regs();
        check_outs();
    endtask

    task automatic t_voltage();
        logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h18, 5'h1B, 5'h1C, 5'h1F};
        for (int n = 0; n < 4; n++) begin
            for (int i = 0; i < 6; i++) begin
                vm[n] = {1'(i + n), codes[i]};
                wr_reg(vidx(n), {26'h0, vm[n]}, 4'hF);
                check_outs();
                rd_chk("raw code readback", vidx(n), {26'h0, vm[n]});
            end
        end
    endtask

    task automatic t_reserved();
        wr_reg(vidx(1) + 6'h01, 32'hFFFF_FFFF, 4'hF);
        em[1] = 6'h3F;
        rd_chk("reserved bits", vidx(1) + 6'h01, 32'h0000_003F);
        wr_reg(vidx(2), 32'h0000_00C5, 4'hE);
        rd_chk("write without byte 0", vidx(2), {26'h0, vm[2]});
        wr_reg(6'h30, 32'h0000_0015, 4'hF);
        rd_chk("unmapped index", 6'h30, 32'h0);
        wr_reg(RCR_IDX_STATUS, 32'h0000_003F, 4'hF);
        check_outs();
    endtask

    task automatic t_gating();
        for (int n = 0; n < 4; n++) begin
            for (int e = 0; e < 16; e++) begin
                em[n] = 6'(e);
                wr_reg(vidx(n) + 6'h01, 32'(e), 4'hF);
                for (int g = 0; g < 8; g++) begin
                    @(posedge mclk);
                    gpio_level <= 3'(g);
                    check_outs();
                end
                rd_chk("status on bits", RCR_IDX_STATUS, {28'h0, 1'(em[3][0] | |(em[3][3:1])),
                    1'(em[2][0] | |(em[2][3:1])), 1'(em[1][0] | |(em[1][3:1])), 1'(em[0][0] | |(em[0][3:1]))});
            end
        end
    endtask

    task automatic t_phase();
        for (int n = 0; n < 4; n++) begin
            for (int p = 0; p < 4; p++) begin
                em[n] = {2'(p), 4'h1};
                wr_reg(vidx(n) + 6'h01, {26'h0, em[n]}, 4'hF);
                check_outs();
            end
        end
    endtask

    task automatic t_standby();
        for (int n = 0; n < 4; n++) begin
            wr_reg(vidx(n), 32'h0000_002A, 4'hF);
            wr_reg(vidx(n) + 6'h01, 32'h0000_000F, 4'hF);
        end
        @(posedge mclk);
        standby_entry <= 1'b1;
        @(posedge mclk);
        standby_entry <= 1'b0;
        load_init();
        check_regs();
        check_outs();
    endtask

    initial begin
        reset_n = 1'b0;
        standby_entry = 1'b0;
        gpio_level = 3'h0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset_values();
        t_voltage();
        t_reserved();
        t_gating();
        t_phase();
        @(posedge mclk);
        gpio_level <= 3'h7;
        t_standby();
        end_sim();
    end
endmodule
